// File: core/spl_pkg.sv
// Constants for the stack pointer and stack limit check block.
// Assumes a 16-bit data space with word-aligned stack accesses.
`default_nettype none

package spl_pkg;

	// ============================================================
	// Register map
	localparam logic [3:0]  ADDR_STACK_PTR   = 4'h0;
	localparam logic [3:0]  ADDR_STACK_LIMIT = 4'h1;
	localparam logic [3:0]  ADDR_INT_STATUS  = 4'h2;
	localparam logic [3:0]  ADDR_INT_MASK    = 4'h3;

	// ============================================================
	// Field positions and values
	localparam int          STAT_OVERFLOW_BIT  = 0;
	localparam int          STAT_UNDERFLOW_BIT = 1;
	localparam int          STAT_WIDTH         = 2;
	localparam logic [15:0] SP_RESET           = 16'h0800;
	localparam logic [15:0] SP_UNDERFLOW_BOUND = 16'h0800;
	localparam logic [15:0] WORD_STEP          = 16'h0002;
	localparam logic [15:0] ALIGN_MASK         = 16'hFFFE;
	localparam logic [7:0]  ZERO_BYTE          = 8'h00;

	// ============================================================
	// Stack operation codes from the core
	localparam logic [1:0]  OP_NONE     = 2'h0;
	localparam logic [1:0]  OP_PUSH     = 2'h1;
	localparam logic [1:0]  OP_POP      = 2'h2;
	localparam logic [1:0]  OP_INDIRECT = 2'h3;

	// ============================================================
	// Kinds of pushed value
	localparam logic [1:0]  PUSH_DATA   = 2'h0;
	localparam logic [1:0]  PUSH_PC_LO  = 2'h1;
	localparam logic [1:0]  PUSH_CALL_HI = 2'h2;
	localparam logic [1:0]  PUSH_EXC_HI = 2'h3;

endpackage

`default_nettype wire

// File: core/spl_stack_check.sv
// Stack pointer register, stack limit register and stack error check.
// Assumes the core issues at most one stack operation per cycle and
// drives its request signals synchronously to sys_clk.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Stack pointer register holds first free word.
// - Stack grows upward toward higher addresses.
// - Push writes then increments; pop decrements then reads.
// - Call push clears byte above PC upper byte.
// - Exception push joins status low byte, PC upper.
// - Stack limit register has no reset value.
// - Stack limit bit zero always reads zero.
// - Every stack-pointer address compared against stack limit.
// - Push at limit passes; next push traps.
// - Address below 0800h raises underflow trap.
module spl_stack_check (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic [1:0]  stack_op,
	input  wire logic [1:0]  push_kind,
	input  wire logic [15:0] push_data,
	input  wire logic [15:0] indirect_addr,
	input  wire logic [7:0]  status_low_byte,
	output logic      [15:0] effective_address,
	output logic      [15:0] mem_wdata,
	output logic             mem_we,
	output logic             mem_re,
	output logic             stack_trap,
	output logic             irq
);

	// ============================================================
	// Address check shared by all stack-pointer based accesses
	function automatic logic [1:0] check_addr(input logic [15:0] addr,
	                                          input logic [15:0] limit,
	                                          input logic        is_push);
		logic over;
		logic under;
		over = 1'b0;
		under = 1'b0;
		// Overflow when a push writes past the limit word.
		if (is_push && (addr > limit)) begin
			over = 1'b1;
		end
		if (!is_push && (addr > limit + spl_pkg::WORD_STEP)) begin
			over = 1'b1;
		end
		if (addr < spl_pkg::SP_UNDERFLOW_BOUND) begin
			under = 1'b1;
		end
		check_addr = {under, over};
	endfunction

	// ============================================================
	// Register index decode shared by the write and read paths.
	// The select is one-hot: stack pointer, limit, status, then mask.
	function automatic logic [3:0] decode_index(input logic [3:0] index,
	                                            input logic       strobe);
		logic [3:0] sel;
		sel = 4'h0;
		if (strobe) begin
			case (index)
				spl_pkg::ADDR_STACK_PTR: begin
					sel = 4'h1;
				end
				spl_pkg::ADDR_STACK_LIMIT: begin
					sel = 4'h2;
				end
				spl_pkg::ADDR_INT_STATUS: begin
					sel = 4'h4;
				end
				spl_pkg::ADDR_INT_MASK: begin
					sel = 4'h8;
				end
				default: begin
					sel = 4'h0;
				end
			endcase
		end
		decode_index = sel;
	endfunction

	// ============================================================
	// Word placed on the memory write port for each kind of push
	// The upper word of a pushed program counter has its top byte in bits 7:0.
	function automatic logic [15:0] push_word(input logic [1:0]  kind,
	                                          input logic [15:0] data,
	                                          input logic [7:0]  status_byte);
		logic [15:0] word;
		word = data;
		case (kind)
			spl_pkg::PUSH_CALL_HI: begin
				// Zero extension keeps the pushed upper byte clear.
				word = {spl_pkg::ZERO_BYTE, data[7:0]};
			end
			spl_pkg::PUSH_EXC_HI: begin
				// The status low byte rides above the top program counter byte.
				word = {status_byte, data[7:0]};
			end
			spl_pkg::PUSH_PC_LO: begin
				word = data;
			end
			default: begin
				word = data;
			end
		endcase
		push_word = word;
	endfunction

	// ============================================================
	// Word alignment shared by the pointer, the limit and indirect addresses
	function automatic logic [15:0] word_align(input logic [15:0] value);
		word_align = value & spl_pkg::ALIGN_MASK;
	endfunction

	// ============================================================
	// State
	logic [15:0] stack_pointer_reg_r;
	logic [15:0] stack_pointer_reg_nxt;
	logic [15:0] stack_limit_reg_r;
	logic [15:0] stack_limit_reg_nxt;
	logic [1:0]  status_r;
	logic [1:0]  status_nxt;
	logic [1:0]  mask_r;
	logic [1:0]  mask_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic [15:0] eff_addr_r;
	logic [15:0] eff_addr_nxt;
	logic [15:0] wdata_r;
	logic [15:0] wdata_nxt;
	logic        we_r;
	logic        we_nxt;
	logic        re_r;
	logic        re_nxt;
	logic        trap_r;
	logic        trap_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic [1:0]  clr_bits;
	logic [15:0] acc_addr;
	logic [1:0]  acc_err;
	logic        acc_push;
	logic        acc_pop;
	logic        acc_read;
	logic        acc_valid;
	logic [3:0]  wr_sel;
	logic [3:0]  rd_sel;

	// ============================================================
	// Stack access decode
	// Forms and checks the address of this cycle's stack access, if any.
	assign wr_sel = decode_index(reg_addr, reg_wr);
	assign rd_sel = decode_index(reg_addr, reg_rd);

	always_comb begin
		acc_addr = stack_pointer_reg_r;
		acc_err = 2'h0;
		acc_push = 1'b0;
		acc_pop = 1'b0;
		acc_read = 1'b0;
		acc_valid = 1'b0;
		case (stack_op)
			spl_pkg::OP_PUSH: begin
				// Write at the free word; the step upward follows.
				acc_addr = stack_pointer_reg_r;
				acc_push = 1'b1;
				acc_valid = 1'b1;
			end
			spl_pkg::OP_POP: begin
				// Step down first, then read the word below.
				acc_addr = 16'(stack_pointer_reg_r - spl_pkg::WORD_STEP);
				acc_pop = 1'b1;
				acc_read = 1'b1;
				acc_valid = 1'b1;
			end
			spl_pkg::OP_INDIRECT: begin
				acc_addr = word_align(indirect_addr);
				acc_read = 1'b1;
				acc_valid = 1'b1;
			end
			default: begin
				acc_addr = stack_pointer_reg_r;
			end
		endcase
		if (acc_valid) begin
			// Every access formed from the stack pointer is checked.
			acc_err = check_addr(acc_addr, stack_limit_reg_r, acc_push);
		end
	end

	// ============================================================
	// Stack pointer register
	// Always holds the address of the first free word on the stack.
	always_comb begin
		stack_pointer_reg_nxt = stack_pointer_reg_r;
		if (acc_push) begin
			stack_pointer_reg_nxt = 16'(stack_pointer_reg_r + spl_pkg::WORD_STEP);
		end
		if (acc_pop) begin
			stack_pointer_reg_nxt = acc_addr;
		end
		// A trap does not hold back the pointer update, and a software
		// write of the pointer in the same cycle wins over both.
		if (wr_sel[0]) begin
			stack_pointer_reg_nxt = word_align(reg_wdata);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			stack_pointer_reg_r <= spl_pkg::SP_RESET;
		end else begin
			stack_pointer_reg_r <= stack_pointer_reg_nxt;
		end
	end

	// ============================================================
	// Stack limit register
	// The limit has no reset value; software must load it before the
	// first checked access, or the trap outputs are undefined.
	always_comb begin
		stack_limit_reg_nxt = stack_limit_reg_r;
		if (wr_sel[1]) begin
			// Bit zero is dropped because stack accesses are word-aligned.
			stack_limit_reg_nxt = word_align(reg_wdata);
		end
	end

	// A new limit applies from the cycle after the write; the core keeps a gap before the
	// next access through the stack pointer.
	always_ff @(posedge sys_clk) begin
		stack_limit_reg_r <= stack_limit_reg_nxt;
	end

	// ============================================================
	// Stack error status, mask and interrupt
	always_comb begin
		clr_bits = 2'h0;
		mask_nxt = mask_r;
		if (wr_sel[2]) begin
			clr_bits = reg_wdata[spl_pkg::STAT_WIDTH-1:0];
		end
		if (wr_sel[3]) begin
			mask_nxt = reg_wdata[spl_pkg::STAT_WIDTH-1:0];
		end
		// A new error wins over a clear in the same cycle.
		status_nxt = (status_r & ~clr_bits) | acc_err;
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			status_r <= 2'h0;
			mask_r <= 2'h0;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ============================================================
	// Register read port
	// Read data stand for one cycle after the strobe and are zero otherwise.
	always_comb begin
		rdata_nxt = 16'h0000;
		case (rd_sel)
			4'h1: begin
				rdata_nxt = stack_pointer_reg_r;
			end
			4'h2: begin
				rdata_nxt = word_align(stack_limit_reg_r);
			end
			4'h4: begin
				rdata_nxt = {14'h0000, status_r};
			end
			4'h8: begin
				rdata_nxt = {14'h0000, mask_r};
			end
			default: begin
				rdata_nxt = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ============================================================
	// Memory port and trap request
	// Address and write data hold between accesses; strobes and the
	// trap request are one-cycle pulses in the cycle after the check.
	always_comb begin
		eff_addr_nxt = eff_addr_r;
		wdata_nxt = wdata_r;
		we_nxt = acc_push;
		re_nxt = acc_read;
		if (acc_valid) begin
			eff_addr_nxt = acc_addr;
		end
		if (acc_push) begin
			wdata_nxt = push_word(push_kind, push_data, status_low_byte);
		end
		// Overflow and underflow share one trap request.
		trap_nxt = |acc_err;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			eff_addr_r <= 16'h0000;
			wdata_r <= 16'h0000;
			we_r <= 1'b0;
			re_r <= 1'b0;
			trap_r <= 1'b0;
		end else begin
			eff_addr_r <= eff_addr_nxt;
			wdata_r <= wdata_nxt;
			we_r <= we_nxt;
			re_r <= re_nxt;
			trap_r <= trap_nxt;
		end
	end

	// ============================================================
	// Outputs
	assign reg_rdata = rdata_r;
	assign effective_address = eff_addr_r;
	assign mem_wdata = wdata_r;
	assign mem_we = we_r;
	assign mem_re = re_r;
	assign stack_trap = trap_r;
	assign irq = irq_r;

endmodule

`default_nettype wire

// File: tb/spl_core_model.sv
// Model of the core address logic that issues stack accesses.
// Assumes the bench calls op just after a rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module spl_core_model (
	input  wire logic        sys_clk,
	input  wire logic        lim_wr,
	output logic      [1:0]  stack_op,
	output logic      [1:0]  push_kind,
	output logic      [15:0] push_data,
	output logic      [15:0] indirect_addr,
	output logic      [7:0]  status_low_byte
);
	logic guard = 1'b0;
	initial begin
		{stack_op, push_kind, push_data, indirect_addr, status_low_byte} = '0;
	end
	always @(negedge sys_clk) begin
		guard = lim_wr;
	end
	task automatic op(input logic [1:0] o, k, input logic [15:0] d);
		if (guard)
			@(posedge sys_clk);
		stack_op <= o;
		push_kind <= k;
		push_data <= d;
		indirect_addr <= d;
		status_low_byte <= ~d[15:8];
	endtask
endmodule
`default_nettype wire

// File: tb/spl_sva.sv
// Assertions on the ports of the stack limit block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module spl_sva (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [1:0]  stack_op,
	input wire logic [1:0]  push_kind,
	input wire logic [15:0] push_data,
	input wire logic [7:0]  status_low_byte,
	input wire logic [15:0] effective_address,
	input wire logic [15:0] mem_wdata,
	input wire logic        mem_we,
	input wire logic        mem_re,
	input wire logic        stack_trap
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_push;
		stack_op == 2'h1 && !reg_wr;
	endsequence
	sequence s_gap;
		stack_op == 2'h0 && !reg_wr;
	endsequence
	// ============================================================
	// Checks
	AST_PUSH_WE: assert property (stack_op == 2'h1 |=> mem_we && !mem_re)
		else $error("push gave no write");
	AST_POP_RE: assert property (stack_op == 2'h2 |=> mem_re && !mem_we)
		else $error("pop gave no read");
	AST_GROW: assert property (s_push ##1 s_gap ##1 s_push
		|=> effective_address == $past(effective_address, 2) + 16'h0002)
		else $error("stack did not grow by one word");
	AST_CALL_HI: assert property (stack_op == 2'h1 && push_kind == 2'h2
		|=> mem_wdata == {8'h00, $past(push_data[7:0])})
		else $error("call upper word not clear");
	AST_EXC_HI: assert property (stack_op == 2'h1 && push_kind == 2'h3
		|=> mem_wdata == {$past(status_low_byte), $past(push_data[7:0])})
		else $error("exception upper word wrong");
	AST_LIMIT_BIT: assert property (reg_rd && reg_addr == 4'h1 |=> !reg_rdata[0])
		else $error("limit bit zero set");
	AST_UNDER: assert property (stack_op != 2'h0
		|=> effective_address >= 16'h0800 || stack_trap)
		else $error("underflow not trapped");
	AST_TRAP_CAUSE: assert property (stack_trap |-> $past(stack_op) != 2'h0)
		else $error("trap without stack access");
endmodule
bind spl_stack_check spl_sva u_sva (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata, .stack_op, .push_kind, .push_data, .status_low_byte,
	.effective_address, .mem_wdata, .mem_we, .mem_re, .stack_trap);
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the stack limit block.
// Assumes spl_core_model drives the stack access inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata, push_data, indirect_addr, effective_address, mem_wdata;
	logic [1:0]  stack_op, push_kind;
	logic [7:0]  status_low_byte;
	logic        mem_we, mem_re, stack_trap, irq;
	int          failures = 0;
	int          total_checks = 0;
	spl_stack_check DUT (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .stack_op, .push_kind, .push_data, .indirect_addr, .status_low_byte,
		.effective_address, .mem_wdata, .mem_we, .mem_re, .stack_trap, .irq);
	spl_core_model m (.sys_clk, .lim_wr(reg_wr && reg_addr == 4'h1), .stack_op,
		.push_kind, .push_data, .indirect_addr, .status_low_byte);
	task automatic chk(input string nm, input logic [15:0] e, g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk("rdata", e, reg_rdata);
		@(posedge sys_clk);
	endtask
	task automatic so(input logic [1:0] o, k, input logic [15:0] d, e, input logic t);
		m.op(o, k, d);
		@(posedge sys_clk);
		m.op(2'h0, k, d);
		@(negedge sys_clk);
		chk("addr", e, effective_address);
		chk("trap", {15'h0, t}, {15'h0, stack_trap});
		chk("we_re", {14'h0, o == 2'h1, o[1]}, {14'h0, mem_we, mem_re});
		@(posedge sys_clk);
	endtask
	task automatic t_over();
		rd(4'h0, 16'h0800);
		wr(4'h1, 16'h0DF5);
		rd(4'h1, 16'h0DF4);
		rd(4'hF, 16'h0000);
		wr(4'h0, 16'h0DF2);
		so(2'h1, 2'h0, 16'h1111, 16'h0DF2, 1'b0);
		so(2'h1, 2'h0, 16'h2222, 16'h0DF4, 1'b0);
		so(2'h1, 2'h0, 16'h3333, 16'h0DF6, 1'b1);
		rd(4'h0, 16'h0DF8);
		so(2'h2, 2'h0, 16'h0000, 16'h0DF6, 1'b0);
		so(2'h3, 2'h0, 16'h0DF8, 16'h0DF8, 1'b1);
		so(2'h3, 2'h0, 16'h0DF7, 16'h0DF6, 1'b0);
		$display("done over");
	endtask
	task automatic t_kinds();
		wr(4'h0, 16'h0900);
		so(2'h1, 2'h2, 16'hFFFF, 16'h0900, 1'b0);
		chk("wdata", 16'h00FF, mem_wdata);
		so(2'h1, 2'h3, 16'h123C, 16'h0902, 1'b0);
		chk("wdata", 16'hED3C, mem_wdata);
		$display("done kinds");
	endtask
	task automatic t_under();
		wr(4'h0, 16'h0800);
		so(2'h2, 2'h0, 16'h0000, 16'h07FE, 1'b1);
		rd(4'h2, 16'h0003);
		wr(4'h3, 16'h0003);
		chk("irq", 16'h0001, {15'h0, irq});
		wr(4'h2, 16'h0003);
		chk("irq", 16'h0000, {15'h0, irq});
		$display("done under");
	endtask
	task automatic t_reset();
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rd(4'h0, 16'h0800);
		rd(4'h1, 16'h0DF4);
		rd(4'h2, 16'h0000);
		$display("done reset");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		t_over();
		t_kinds();
		t_under();
		t_reset();
		test_done();
	end
	initial begin
		repeat (2000) @(posedge sys_clk);
		failures++;
		test_done();
	end
endmodule
`default_nettype wire
